// *** src/amd_div.sv ***
`timescale 1ns/1ns
module amd_div (
    input logic pclk,
    input logic presetn,
    input logic start,
    input logic signed_mode,
    input logic hold,
    input logic [2*amd_pkg::DW-1:0] dividend,
    input logic [amd_pkg::DW-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [amd_pkg::DW-1:0] quot,
    output logic [amd_pkg::DW-1:0] rem
);
    import amd_pkg::*;

    amd_dv_st_t st_reg;
    logic [4:0] cnt_reg;
    logic [17:0] r_reg, sh, r_it;
    logic [DW-1:0] q_reg, d_reg;
    logic [2*DW-1:0] dvd_reg, mag;
    logic sgn_reg, neg_q_reg, neg_r_reg;

    assign busy = st_reg != DV_IDLE;

    // Non-restoring step: the sign of the partial remainder picks add or subtract.
    always_comb begin
        mag = (sgn_reg && dvd_reg[2*DW-1]) ? 32'(-dvd_reg) : dvd_reg;
        sh = {r_reg[16:0], q_reg[DW-1]};
        r_it = r_reg[17] ? sh + {2'b00, d_reg} : sh - {2'b00, d_reg};
    end

    // Hold freezes every state but DV_IDLE, so a running divide can be suspended at any cycle boundary.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= DV_IDLE;
            cnt_reg <= 5'h00;
            r_reg <= 18'h00000;
            q_reg <= W_RST;
            d_reg <= W_RST;
            dvd_reg <= 32'h00000000;
            sgn_reg <= 1'b0;
            neg_q_reg <= 1'b0;
            neg_r_reg <= 1'b0;
            done <= 1'b0;
            quot <= W_RST;
            rem <= W_RST;
        end else begin
            done <= 1'b0;
            unique case (st_reg)
                DV_IDLE: if (start) begin
                    dvd_reg <= dividend;
                    d_reg <= divisor;
                    sgn_reg <= signed_mode;
                    st_reg <= DV_LOAD;
                end
                DV_LOAD: if (!hold) begin
                    neg_q_reg <= sgn_reg && (dvd_reg[2*DW-1] ^ d_reg[DW-1]);
                    neg_r_reg <= sgn_reg && dvd_reg[2*DW-1];
                    d_reg <= (sgn_reg && d_reg[DW-1]) ? 16'(-d_reg) : d_reg;
                    r_reg <= {2'b00, mag[2*DW-1:DW]};
                    q_reg <= mag[DW-1:0];
                    cnt_reg <= 5'h00;
                    st_reg <= DV_ITER;
                end
                DV_ITER: if (!hold) begin
                    r_reg <= r_it;
                    q_reg <= {q_reg[DW-2:0], ~r_it[17]};
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == DIV_LAST) begin
                        st_reg <= DV_CORR;
                    end
                end
                DV_CORR: if (!hold) begin
                    if (r_reg[17]) begin
                        r_reg <= r_reg + {2'b00, d_reg};
                    end
                    st_reg <= DV_SIGN;
                end
                DV_SIGN: if (!hold) begin
                    quot <= neg_q_reg ? 16'(-q_reg) : q_reg;
                    rem <= neg_r_reg ? 16'(-r_reg[DW-1:0]) : r_reg[DW-1:0];
                    done <= 1'b1;
                    st_reg <= DV_IDLE;
                end
                default: st_reg <= DV_IDLE;
            endcase
        end
    end

endmodule

// *** src/amd_pkg.sv ***
package amd_pkg;

    localparam int AW = 8;
    localparam int BW = 32;
    localparam int DW = 16;
    localparam int NUM_W = 16;

    localparam logic [AW-1:0] ADDR_W0 = 8'h00;
    localparam logic [AW-1:0] ADDR_CTRL = 8'h40;
    localparam logic [AW-1:0] ADDR_MEMIN = 8'h44;
    localparam logic [AW-1:0] ADDR_MEMOUT = 8'h48;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h4c;
    localparam int W_IDX_HI = 5;
    localparam int W_IDX_LO = 2;

    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_OV = 2;
    localparam int SR_N = 3;
    localparam int SR_DC = 8;
    localparam int ST_BUSY = 16;
    localparam int ST_HOLD = 17;

    localparam logic [DW-1:0] W_RST = 16'h0000;
    localparam logic [4:0] DIV_LAST = 5'h0f;
    localparam logic [4:0] DIV_CYCLES = 5'h13;

    typedef enum logic [4:0] {
        OP_ADD = 5'h00,
        OP_SUB = 5'h01,
        OP_AND = 5'h02,
        OP_IOR = 5'h03,
        OP_XOR = 5'h04,
        OP_ASR = 5'h05,
        OP_SL = 5'h06,
        OP_LSR = 5'h07,
        OP_MUL_SS = 5'h08,
        OP_MUL_UU = 5'h09,
        OP_MUL_SU = 5'h0a,
        OP_MUL_US = 5'h0b,
        OP_MUL_SL = 5'h0c,
        OP_MUL_UL = 5'h0d,
        OP_MUL_BB = 5'h0e,
        OP_DIV_S32 = 5'h10,
        OP_DIV_U32 = 5'h11,
        OP_DIV_S16 = 5'h12,
        OP_DIV_U16 = 5'h13
    } amd_op_t;

    typedef struct packed {
        logic [5:0] rsv;
        logic use_lit;
        logic [4:0] lit;
        logic [3:0] wd;
        logic [3:0] wb;
        logic [3:0] ws;
        logic dst_mem;
        logic src_mem;
        logic byte_mode;
        amd_op_t op;
    } amd_cmd_t;

    typedef struct packed {
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic c;
    } amd_flags_t;

    localparam amd_flags_t FLAGS_RST = 5'h00;

    typedef struct packed {
        logic [DW-1:0] res;
        logic c;
        logic dc;
        logic ov;
    } amd_sum_t;

    typedef enum logic [2:0] {
        DV_IDLE = 3'b000,
        DV_LOAD = 3'b001,
        DV_ITER = 3'b010,
        DV_CORR = 3'b011,
        DV_SIGN = 3'b100
    } amd_dv_st_t;

endpackage

// *** src/amd_top.sv ***
// What this block does
// - Sixteen-bit add, subtract, shift and logic operations in two's complement.
// - Operations update carry, zero, negative, overflow and digit carry status.
// - On subtraction carry means no borrow and digit carry means no digit borrow.
// - Add, subtract, logic and shift operations run at byte or word width as the command selects.
// - Operands come from working registers or memory; results go likewise.
// - A 17 by 17 multiplier handles unsigned, signed and mixed operands.
// - Multiply modes: word signed, unsigned, mixed, word by literal, byte by byte.
// - Divide signed or unsigned, 32 or 16 bit dividend by 16 bit divisor.
// - Every divide writes quotient to register zero and remainder to register one.
// - Divisor is any register; 32 bit dividend is an aligned pair, high odd.
// - One iteration per divisor bit, so both dividend sizes take equal time.
// - Single-cycle shifts of up to fifteen positions left or right.
// - Multi-bit shifts read and write working registers only.
// - Shift ops are arithmetic right, left and logical right.
// - A divide takes nineteen cycles, non-restoring, and can be held any cycle.
// - Digit carry is carry out of bit three for bytes, bit seven for words.
// - Overflow flags signed overflow, or a zero divisor after a divide; negative flags a negative result.
`timescale 1ns/1ns
module amd_top (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [amd_pkg::AW-1:0] paddr,
    input logic [amd_pkg::BW-1:0] pwdata,
    output logic [amd_pkg::BW-1:0] prdata,
    output logic pready,
    output logic pslverr
);
    import amd_pkg::*;

    logic [DW-1:0] w_reg [NUM_W];
    amd_cmd_t cmd_reg;
    logic go_reg, hold_reg, div_dz_reg;
    logic [BW-1:0] memin_reg, memout_reg, rd_data;
    amd_flags_t flags_reg, flags_next;
    amd_sum_t sum;
    logic [4:0] div_run_cnt;
    logic div_start, div_busy, div_done, div_signed;
    logic [DW-1:0] div_quot, div_rem, div_dsr;
    logic [2*DW-1:0] div_dvd;
    logic [DW-1:0] a_op, b_op, ext, res, res_lo, res_hi;
    logic [16:0] shl, shr;
    logic [33:0] prod;
    logic signed [31:0] chk_sl;
    logic [3:0] wd_lo, wd_hi, sh_cnt;
    logic wr_w, wr_pair, wr_mem, is_shift, is_mul, is_div, bm, sa, sb;
    logic load, mapped, wr_ok;

    function automatic amd_sum_t add_core(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                          input logic cin, input logic byte_mode);
        amd_sum_t o;
        logic [16:0] s;
        logic [8:0] h;
        logic [4:0] q;
        s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
        h = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
        q = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        o.res = s[DW-1:0];
        if (byte_mode) begin
            o.c = h[8];
            o.dc = q[4];
            o.ov = (a[7] == b[7]) && (h[7] != a[7]);
        end else begin
            o.c = s[16];
            o.dc = h[8];
            o.ov = (a[15] == b[15]) && (s[15] != a[15]);
        end
        return o;
    endfunction

    function automatic logic [16:0] ext17(input logic [DW-1:0] v, input logic sgn);
        return {sgn & v[DW-1], v};
    endfunction

    // Register bus. Answers are held off while a result is being written back so
    // that a read never returns a value one cycle stale.
    assign load = psel && !pready && !go_reg && !div_done;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_STATUS);
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        rd_data = 32'h00000000;
        if (paddr < ADDR_CTRL) begin
            rd_data = {16'h0000, w_reg[paddr[W_IDX_HI:W_IDX_LO]]};
        end else if (paddr == ADDR_CTRL) begin
            rd_data = cmd_reg;
        end else if (paddr == ADDR_MEMIN) begin
            rd_data = memin_reg;
        end else if (paddr == ADDR_MEMOUT) begin
            rd_data = memout_reg;
        end else if (paddr == ADDR_STATUS) begin
            rd_data[SR_C] = flags_reg.c;
            rd_data[SR_Z] = flags_reg.z;
            rd_data[SR_OV] = flags_reg.ov;
            rd_data[SR_N] = flags_reg.n;
            rd_data[SR_DC] = flags_reg.dc;
            rd_data[ST_BUSY] = div_busy;
            rd_data[ST_HOLD] = hold_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= load;
            pslverr <= load && (!mapped || (pwrite && div_busy && paddr != ADDR_STATUS));
            prdata <= (load && !pwrite && mapped) ? rd_data : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= 32'h00000000;
            go_reg <= 1'b0;
            memin_reg <= 32'h00000000;
            hold_reg <= 1'b0;
        end else begin
            go_reg <= wr_ok && paddr == ADDR_CTRL;
            if (wr_ok && paddr == ADDR_CTRL) begin
                cmd_reg <= amd_cmd_t'(pwdata);
            end
            if (wr_ok && paddr == ADDR_MEMIN) begin
                memin_reg <= pwdata;
            end
            if (wr_ok && paddr == ADDR_STATUS) begin
                hold_reg <= pwdata[ST_HOLD];
            end
        end
    end

    // Operand fetch.
    assign is_shift = cmd_reg.op inside {OP_ASR, OP_SL, OP_LSR};
    assign is_mul = cmd_reg.op inside {[OP_MUL_SS:OP_MUL_BB]};
    assign is_div = cmd_reg.op inside {[OP_DIV_S32:OP_DIV_U16]};
    assign bm = cmd_reg.byte_mode && !is_mul && !is_div;
    assign a_op = (cmd_reg.src_mem && !is_shift) ? memin_reg[DW-1:0] : w_reg[cmd_reg.ws];
    assign b_op = (cmd_reg.use_lit || cmd_reg.op inside {OP_MUL_SL, OP_MUL_UL}) ?
                  {11'h000, cmd_reg.lit} : w_reg[cmd_reg.wb];
    assign sh_cnt = b_op[3:0];
    assign sa = cmd_reg.op inside {OP_MUL_SS, OP_MUL_SU, OP_MUL_SL};
    assign sb = cmd_reg.op inside {OP_MUL_SS, OP_MUL_US};
    assign chk_sl = 32'($signed(a_op)) * 32'($signed({11'h000, cmd_reg.lit}));

    // Divide launch.
    assign div_start = go_reg && is_div;
    assign div_signed = cmd_reg.op inside {OP_DIV_S32, OP_DIV_S16};
    assign div_dsr = w_reg[cmd_reg.wb];
    always_comb begin
        unique case (cmd_reg.op)
            OP_DIV_S32, OP_DIV_U32: div_dvd = {w_reg[{cmd_reg.ws[3:1], 1'b1}], w_reg[{cmd_reg.ws[3:1], 1'b0}]};
            OP_DIV_S16: div_dvd = {{DW{w_reg[cmd_reg.ws][DW-1]}}, w_reg[cmd_reg.ws]};
            default: div_dvd = {16'h0000, w_reg[cmd_reg.ws]};
        endcase
    end

    amd_div amd_div_inst (
        .pclk(pclk),
        .presetn(presetn),
        .start(div_start),
        .signed_mode(div_signed),
        .hold(hold_reg),
        .dividend(div_dvd),
        .divisor(div_dsr),
        .busy(div_busy),
        .done(div_done),
        .quot(div_quot),
        .rem(div_rem)
    );

    // Single-cycle datapath.
    always_comb begin
        flags_next = flags_reg;
        sum = add_core(a_op, (cmd_reg.op == OP_SUB) ? ~b_op : b_op, cmd_reg.op == OP_SUB, bm);
        ext = bm ? (cmd_reg.op == OP_ASR ? {{8{a_op[7]}}, a_op[7:0]} : {8'h00, a_op[7:0]}) : a_op;
        shl = {1'b0, ext} << sh_cnt;
        shr = (cmd_reg.op == OP_ASR) ? 17'($signed({ext, 1'b0}) >>> sh_cnt) : {ext, 1'b0} >> sh_cnt;
        prod = 34'($signed(ext17(a_op, sa))) * 34'($signed(ext17(b_op, sb)));
        res = 16'h0000;
        res_hi = prod[2*DW-1:DW];
        wd_lo = cmd_reg.wd;
        wd_hi = cmd_reg.wd;
        wr_pair = 1'b0;
        unique case (cmd_reg.op)
            OP_ADD, OP_SUB: begin
                res = sum.res;
                flags_next.c = sum.c;
                flags_next.dc = sum.dc;
                flags_next.ov = sum.ov;
            end
            OP_AND: res = a_op & b_op;
            OP_IOR: res = a_op | b_op;
            OP_XOR: res = a_op ^ b_op;
            OP_SL: begin
                res = shl[DW-1:0];
                flags_next.c = (sh_cnt == 4'h0) ? flags_reg.c : (bm ? shl[8] : shl[16]);
            end
            OP_ASR, OP_LSR: begin
                res = shr[16:1];
                flags_next.c = (sh_cnt == 4'h0) ? flags_reg.c : shr[0];
            end
            OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_SL, OP_MUL_UL: begin
                res = prod[DW-1:0];
                wd_lo = {cmd_reg.wd[3:1], 1'b0};
                wd_hi = {cmd_reg.wd[3:1], 1'b1};
                wr_pair = 1'b1;
            end
            OP_MUL_BB: begin
                prod = 34'(a_op[7:0]) * 34'(b_op[7:0]);
                res = prod[DW-1:0];
            end
            OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16: res = 16'h0000;
            default: res = 16'h0000;
        endcase
        if (!is_mul && !is_div) begin
            flags_next.n = bm ? res[7] : res[15];
            flags_next.z = bm ? (res[7:0] == 8'h00) : (res == 16'h0000);
        end
        wr_mem = go_reg && cmd_reg.dst_mem && !is_shift && !is_mul && !is_div;
        wr_w = go_reg && !wr_mem && !is_div && cmd_reg.op <= OP_MUL_BB;
        wr_pair = wr_pair && wr_w;
        if (bm) begin
            res_lo = wr_mem ? {8'h00, res[7:0]} : {w_reg[cmd_reg.wd][15:8], res[7:0]};
        end else begin
            res_lo = res;
        end
    end

    // Working registers. Bus writes are refused while a divide runs, so they never
    // meet a divide write-back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_W; i++) begin
                w_reg[i] <= W_RST;
            end
        end else if (wr_ok && paddr < ADDR_CTRL) begin
            w_reg[paddr[W_IDX_HI:W_IDX_LO]] <= pwdata[DW-1:0];
        end else if (div_done) begin
            w_reg[0] <= div_quot;
            w_reg[1] <= div_rem;
        end else begin
            if (wr_w) begin
                w_reg[wd_lo] <= res_lo;
            end
            if (wr_pair) begin
                w_reg[wd_hi] <= res_hi;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memout_reg <= 32'h00000000;
        end else if (wr_mem) begin
            memout_reg <= {16'h0000, res_lo};
        end
    end

    // Hardware updates win over a software write to the status register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= FLAGS_RST;
            div_dz_reg <= 1'b0;
        end else begin
            if (div_start) begin
                div_dz_reg <= div_dsr == 16'h0000;
            end
            if (div_done) begin
                flags_reg.ov <= div_dz_reg;
                flags_reg.n <= div_quot[DW-1];
                flags_reg.z <= div_quot == 16'h0000;
            end else if (go_reg) begin
                flags_reg <= flags_next;
            end else if (wr_ok && paddr == ADDR_STATUS && !div_busy) begin
                flags_reg <= {pwdata[SR_DC], pwdata[SR_N], pwdata[SR_OV], pwdata[SR_Z], pwdata[SR_C]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_run_cnt <= 5'h00;
        end else if (div_start) begin
            div_run_cnt <= 5'h00;
        end else if (div_busy && !hold_reg) begin
            div_run_cnt <= div_run_cnt + 5'h01;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_add_carry;
        go_reg && cmd_reg.op == OP_ADD && !cmd_reg.byte_mode |=>
            flags_reg.c == $past((17'(a_op) + 17'(b_op)) > 17'h0ffff);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    property p_sub_borrow;
        go_reg && cmd_reg.op == OP_SUB && !cmd_reg.byte_mode |=> flags_reg.c == $past(a_op >= b_op);
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("sub borrow wrong");

    property p_and_word;
        go_reg && cmd_reg.op == OP_AND && !cmd_reg.byte_mode && !cmd_reg.dst_mem |=>
            w_reg[$past(cmd_reg.wd)] == $past(a_op & b_op);
    endproperty
    a_and_word: assert property (p_and_word) else $error("and result wrong");

    property p_byte_keep;
        go_reg && cmd_reg.byte_mode && !cmd_reg.dst_mem && cmd_reg.op <= OP_XOR |=>
            w_reg[$past(cmd_reg.wd)][15:8] == $past(w_reg[cmd_reg.wd][15:8]);
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("byte op touched high byte");

    property p_mem_dst;
        go_reg && cmd_reg.op == OP_ADD && !cmd_reg.byte_mode && cmd_reg.dst_mem |=>
            memout_reg == {16'h0000, $past(a_op + b_op)};
    endproperty
    a_mem_dst: assert property (p_mem_dst) else $error("memory result wrong");

    property p_mul_sl;
        go_reg && cmd_reg.op == OP_MUL_SL |=>
            {w_reg[$past(wd_hi)], w_reg[$past(wd_lo)]} == $past(chk_sl);
    endproperty
    a_mul_sl: assert property (p_mul_sl) else $error("signed literal product wrong");

    property p_mul_bb;
        go_reg && cmd_reg.op == OP_MUL_BB |=>
            w_reg[$past(cmd_reg.wd)] == $past(16'(a_op[7:0]) * 16'(b_op[7:0]));
    endproperty
    a_mul_bb: assert property (p_mul_bb) else $error("byte product wrong");

    property p_mul_uu;
        go_reg && cmd_reg.op == OP_MUL_UU |=>
            {w_reg[$past(wd_hi)], w_reg[$past(wd_lo)]} == $past(32'(a_op) * 32'(b_op));
    endproperty
    a_mul_uu: assert property (p_mul_uu) else $error("word product wrong");

    property p_div_wb;
        div_done |=> w_reg[0] == $past(div_quot) && w_reg[1] == $past(div_rem);
    endproperty
    a_div_wb: assert property (p_div_wb) else $error("divide write-back wrong");

    property p_div_len;
        div_done |-> div_run_cnt == DIV_CYCLES;
    endproperty
    a_div_len: assert property (p_div_len) else $error("divide length wrong");

    property p_div_busy;
        div_start ##1 (!hold_reg)[*8] |-> div_busy && !div_done;
    endproperty
    a_div_busy: assert property (p_div_busy) else $error("divide ended early");

    property p_shl;
        go_reg && cmd_reg.op == OP_SL && !cmd_reg.byte_mode |=>
            w_reg[$past(cmd_reg.wd)] == $past(a_op << sh_cnt);
    endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong");

    property p_asr;
        go_reg && cmd_reg.op == OP_ASR && !cmd_reg.byte_mode |=>
            w_reg[$past(cmd_reg.wd)] == $past(16'($signed(a_op) >>> sh_cnt));
    endproperty
    a_asr: assert property (p_asr) else $error("arithmetic right shift wrong");

    property p_dc;
        go_reg && cmd_reg.op == OP_ADD && cmd_reg.byte_mode |=>
            flags_reg.dc == $past((5'(a_op[3:0]) + 5'(b_op[3:0])) > 5'h0f);
    endproperty
    a_dc: assert property (p_dc) else $error("digit carry wrong");

    property p_neg;
        go_reg && cmd_reg.op == OP_SUB && !cmd_reg.byte_mode && !cmd_reg.dst_mem |=>
            flags_reg.n == w_reg[$past(cmd_reg.wd)][15];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");

endmodule

// *** tb/amd_host.sv ***
`timescale 1ns/1ns
module amd_host (
    input logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [amd_pkg::AW-1:0] paddr,
    output logic [amd_pkg::BW-1:0] pwdata,
    input logic [amd_pkg::BW-1:0] prdata,
    input logic pready,
    input logic pslverr
);
    import amd_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // The request stands until pready, so a wait state after a command write is never cut short.
    task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [BW-1:0] d,
                        output logic [BW-1:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// *** tb/amd_top_tb.sv ***
`timescale 1ns/1ns
module amd_top_tb;
    import amd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [AW-1:0] paddr;
    logic [BW-1:0] pwdata, prdata, q, hi;
    int n_errors = 0;
    int check_count = 0;
    amd_op_t mop[7] = '{OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_UL, OP_MUL_SL, OP_MUL_BB};
    int mws[7] = '{5, 5, 5, 5, 5, 5, 2};
    int mlit[7] = '{0, 0, 0, 0, 3, 3, 0};
    logic [BW-1:0] mexp[7] = '{32'h40000000, 32'h40000000, 32'hc0000000, 32'hc0000000,
                               32'h00018000, 32'hfffe8000, 32'hfffe0001};
    amd_op_t sop[3] = '{OP_ASR, OP_LSR, OP_SL};
    int sws[3] = '{5, 5, 2};
    int slit[3] = '{4, 15, 15};
    logic [BW-1:0] sexp[3] = '{32'hf800, 32'h0001, 32'h8000};
    always #20 pclk = ~pclk;
    amd_top amd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    amd_host amd_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic chk(input string nm, input logic [BW-1:0] seen, input logic [BW-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [BW-1:0] d);
        amd_host_inst.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [AW-1:0] a);
        amd_host_inst.xfer(1'b0, a, '0, q, e);
    endtask
    function automatic logic [BW-1:0] cmd(input amd_op_t op, input int ws, wb, wd, lit, input logic by);
        return {6'h0, lit != 0, lit[4:0], wd[3:0], wb[3:0], ws[3:0], 2'b00, by, op};
    endfunction
    task automatic div(input amd_op_t op, input int ws, input logic [BW-1:0] qe, re, input logic hd);
        wr(ADDR_CTRL, cmd(op, ws, 7, 0, 0, 1'b0));
        rd(ADDR_STATUS);
        chk("busy", q & 32'h10000, 32'h10000);
        wr(8'h14, 32'h1);
        chk("busy refusal", {31'h0, e}, 32'h1);
        if (hd) begin
            wr(ADDR_STATUS, 32'h20000);
            repeat (10) rd(ADDR_STATUS);
            chk("held", q & 32'h30000, 32'h30000);
            wr(ADDR_STATUS, 32'h0);
        end
        repeat (40) begin
            rd(ADDR_STATUS);
            if (q[ST_BUSY] === 1'b0) break;
        end
        chk("idle", q & 32'h10000, 32'h0);
        rd(ADDR_W0);
        chk("quotient", q, qe);
        rd(8'h04);
        chk("remainder", q, re);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge pclk);
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_STATUS);
        chk("status reset", q, 32'h0);
        wr(8'h04, 32'h7fff);
        wr(8'h08, 32'h0001);
        wr(ADDR_CTRL, cmd(OP_ADD, 1, 2, 3, 0, 1'b0));
        rd(8'h0c);
        chk("add", q, 32'h8000);
        rd(ADDR_STATUS);
        chk("add flags", q, 32'h10c);
        wr(ADDR_CTRL, cmd(OP_SUB, 2, 1, 3, 0, 1'b0));
        rd(8'h0c);
        chk("sub", q, 32'h8002);
        rd(ADDR_STATUS);
        chk("sub flags", q, 32'h008);
        wr(ADDR_CTRL, cmd(OP_ADD, 1, 2, 1, 0, 1'b1));
        rd(8'h04);
        chk("byte add", q, 32'h7f00);
        rd(ADDR_STATUS);
        chk("byte flags", q, 32'h103);
        wr(8'h14, 32'h8000);
        wr(8'h1c, 32'h0007);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, cmd(sop[i], sws[i], 0, 6, slit[i], 1'b0));
            rd(8'h18);
            chk("shift", q, sexp[i]);
        end
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_CTRL, cmd(mop[i], mws[i], mws[i], 8, mlit[i], 1'b0));
            rd(8'h24);
            hi = q;
            rd(8'h20);
            chk("product", {hi[15:0], q[15:0]}, mexp[i]);
        end
        wr(8'h28, 32'h0064);
        wr(8'h2c, 32'h0000);
        wr(ADDR_MEMIN, 32'h0ff0);
        wr(ADDR_CTRL, cmd(OP_ADD, 0, 7, 0, 0, 1'b0) | 32'hc0);
        rd(ADDR_MEMOUT);
        chk("memory add", q, 32'h0ff7);
        wr(ADDR_CTRL, cmd(OP_AND, 7, 10, 13, 0, 1'b0));
        rd(8'h34);
        chk("and", q, 32'h4);
        wr(ADDR_CTRL, cmd(OP_IOR, 7, 10, 14, 0, 1'b0));
        rd(8'h38);
        chk("or", q, 32'h67);
        wr(ADDR_CTRL, cmd(OP_XOR, 7, 7, 12, 0, 1'b0));
        rd(ADDR_STATUS);
        chk("xor flags", q, 32'h2);
        div(OP_DIV_U32, 10, 32'h000e, 32'h0002, 1'b0);
        div(OP_DIV_S16, 5, 32'hedb7, 32'hffff, 1'b1);
        div(OP_DIV_U16, 5, 32'h1249, 32'h0001, 1'b0);
        div(OP_DIV_S32, 8, 32'hb6dc, 32'hfffd, 1'b0);
        rd(8'h50);
        chk("unmapped", {q[30:0], e}, 32'h1);
        print_verdict;
    end
endmodule
